//--- src/ipar_pkg.sv
// constants and carrier types for the init, power mode and alarm register bank
// assumes the serial frame is one read/write bit, a 15-bit address and 8 data bits
package ipar_pkg;

    // serial frame layout
    localparam int unsigned FRAME_BITS   = 24;           // whole frame length
    localparam int unsigned HEADER_BITS  = 16;           // command bit plus address
    localparam int unsigned ADDR_W       = 15;           // register address width
    localparam int unsigned DATA_W       = 8;            // register data width
    localparam int unsigned CMD_READ_POS = 23;           // command bit, 1 means read

    // register offsets
    localparam logic [14:0] OFS_STARTUP_DONE = 15'h0270; // startup_done_flags
    localparam logic [14:0] OFS_MODE_B       = 15'h029A; // power_mode_code_b
    localparam logic [14:0] OFS_MODE_C       = 15'h029B; // power_mode_code_c
    localparam logic [14:0] OFS_MODE_D       = 15'h029C; // power_mode_code_d
    localparam logic [14:0] OFS_ALARM_SUM    = 15'h02C0; // alarm_summary
    localparam logic [14:0] OFS_ALARM_FLAGS  = 15'h02C1; // alarm_sticky_flags

    // mode codes, reset value is the high-performance code
    localparam logic [7:0] MODE_B_LOW  = 8'h06;
    localparam logic [7:0] MODE_B_HIGH = 8'h0F;
    localparam logic [7:0] MODE_C_LOW  = 8'h00;
    localparam logic [7:0] MODE_C_HIGH = 8'h04;
    localparam logic [7:0] MODE_D_LOW  = 8'h14;
    localparam logic [7:0] MODE_D_HIGH = 8'h1B;

    // alarm flag layout
    localparam int unsigned ALARM_W          = 6;        // implemented flag bits 5:0
    localparam logic [5:0]  ALARM_FLAGS_RST  = 6'h3F;    // every flag set after reset
    localparam int unsigned POS_FIFO_FAULT   = 5;
    localparam int unsigned POS_PLL_UNLOCK   = 4;
    localparam int unsigned POS_LINK_DOWN    = 3;
    localparam int unsigned POS_REALIGN      = 2;
    localparam int unsigned POS_SPARE        = 1;        // reserved, set only by reset and soft reset
    localparam int unsigned POS_DIV_MISMATCH = 0;
    localparam logic [7:0]  SUMMARY_RST      = 8'h00;

    // default lane count feeding the fifo fault
    localparam int unsigned LANES_DEFAULT = 8;

    // alarm source events from the surrounding core, same clock
    typedef struct packed {
        logic serializer_pll_unlock;
        logic link_not_running;
        logic clock_realign_event;
        logic divider_mismatch;
    } ipar_alarm_evt_t;

    // one decoded register write
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ipar_wr_t;

endpackage : ipar_pkg

//--- src/ipar_sync.sv
// two flip-flop synchroniser bank for the serial interface pins
// assumes the inputs are asynchronous to i_clk; only stage two is used outside
`timescale 1ns/100ps
module ipar_sync #(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // raw and synchronised levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;       // metastable stage, read by stage two only
    logic [WIDTH-1:0] next_stage1;  // next value of stage one
    logic [WIDTH-1:0] next_sync;    // next value of stage two

    // next values
    always_comb begin
        next_stage1 = i_async;
        next_sync   = stage1;
    end

    // both stages share the reset constant so idle pins read inactive
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            stage1 <= next_stage1;
            o_sync <= next_sync;
        end
    end

endmodule : ipar_sync

//--- src/ipar_regs.sv
// init status, power mode code and alarm registers behind the serial port
// assumes pins are slow against I_MCLK (serial clock under a quarter of it)
// and that init, fifo and alarm sources run on I_MCLK
//
// Behaviour
// - init done drives bit 0, rest zero
// - mode b: 0x06 low, 0x0F high/reset
// - mode c: 0x00 low, 0x04 high/reset
// - mode d: 0x14 low, 0x1B high/reset
// - summary bit 0 is unmasked alarm OR
// - set mask bit removes alarm from summary
// - selected summary drives status output pin
// - alarm flags reset 0x3F, fixed bit layout
// - writing one clears flag, zero keeps
// - any active lane fifo fault sets flag
// - all flags set after reset; host clears
`timescale 1ns/100ps
module ipar_regs #(
    parameter int unsigned LANES = ipar_pkg::LANES_DEFAULT
) (
    // clock and reset
    input  wire logic                     I_MCLK,
    input  wire logic                     I_SYS_RST,
    input  wire logic                     i_SOFT_RESET,
    // serial register port pins
    input  wire logic                     i_SCLK,
    input  wire logic                     i_SCS_N,
    input  wire logic                     i_SDI,
    output logic                          o_SDO,
    output logic                          o_SDO_OE,
    // core status inputs
    input  wire logic                     i_INIT_DONE,
    input  wire logic [LANES-1:0]         i_LANE_ACTIVE,
    input  wire logic [LANES-1:0]         i_LANE_FIFO_UNDERFLOW,
    input  wire logic [LANES-1:0]         i_LANE_FIFO_OVERFLOW,
    input  wire ipar_pkg::ipar_alarm_evt_t i_ALARM_EVENTS,
    // alarm masking and pin routing
    input  wire logic [5:0]               i_ALARM_DISABLE_BITS,
    input  wire logic                     i_STATUS_PIN_SEL_ALARM,
    input  wire logic                     i_CAL_STATUS,
    output logic                          o_STATUS_OUTPUT_PIN,
    // mode codes toward the converter core
    output logic [7:0]                    o_MODE_CODE_B,
    output logic [7:0]                    o_MODE_CODE_C,
    output logic [7:0]                    o_MODE_CODE_D
);

    // synchronised pins: sclk, chip select, data in
    logic [2:0] pins_sync;
    logic       sclk_s;        // serial clock after two flops
    logic       csn_s;         // chip select after two flops
    logic       sdi_s;         // data in after two flops

    ipar_sync #(
        .WIDTH   (3),
        .RST_VAL (3'b010)
    ) ipar_sync_inst (
        .i_clk   (I_MCLK),
        .i_rst   (I_SYS_RST),
        .i_async ({i_SCLK, i_SCS_N, i_SDI}),
        .o_sync  (pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign csn_s  = pins_sync[1];
    assign sdi_s  = pins_sync[0];

    // frame phase of the serial port
    typedef enum logic [1:0] {IPAR_IDLE, IPAR_HEADER, IPAR_DATA} ipar_phase_t;

    // serial engine state
    ipar_phase_t phase;        // current frame phase
    ipar_phase_t next_phase;
    logic        sclk_d;       // last synchronised serial clock, for edges
    logic        next_sclk_d;
    logic [23:0] shift;        // incoming frame bits
    logic [23:0] next_shift;
    logic [4:0]  bit_cnt;      // rising edges seen in this frame
    logic [4:0]  next_bit_cnt;
    logic        is_read;      // frame is a read
    logic        next_is_read;
    logic [7:0]  sdo_shift;    // outgoing read data
    logic [7:0]  next_sdo_shift;
    logic        next_sdo;
    logic        next_sdo_oe;
    ipar_pkg::ipar_wr_t wr;    // write decoded this cycle

    // register bank state
    logic [7:0] mode_b;
    logic [7:0] mode_c;
    logic [7:0] mode_d;
    logic [7:0] next_mode_b;
    logic [7:0] next_mode_c;
    logic [7:0] next_mode_d;
    logic [5:0] flags;         // sticky alarm flags
    logic [5:0] next_flags;
    logic [5:0] set_evt;       // hardware set requests this cycle
    logic [5:0] clr_req;       // software clear requests this cycle
    logic       summary;       // unmasked alarm present
    logic       next_pin;

    // a code that is neither the low nor the high code is reserved
    function automatic logic code_legal(input logic [7:0] code,
                                        input logic [7:0] low,
                                        input logic [7:0] high);
        code_legal = (code == low) || (code == high);
    endfunction : code_legal

    // read mux; unmapped addresses read zero
    function automatic logic [7:0] read_value(input logic [14:0] addr,
                                              input logic [7:0]  mb,
                                              input logic [7:0]  mc,
                                              input logic [7:0]  md,
                                              input logic [5:0]  fl,
                                              input logic        sum,
                                              input logic        done);
        case (addr)
            ipar_pkg::OFS_STARTUP_DONE: read_value = {7'h00, done};
            ipar_pkg::OFS_MODE_B:       read_value = mb;
            ipar_pkg::OFS_MODE_C:       read_value = mc;
            ipar_pkg::OFS_MODE_D:       read_value = md;
            ipar_pkg::OFS_ALARM_SUM:    read_value = {7'h00, sum};
            ipar_pkg::OFS_ALARM_FLAGS:  read_value = {2'b00, fl};
            default:                    read_value = 8'h00;
        endcase
    endfunction : read_value

    // serial engine: sample on rising sclk, shift out on falling sclk
    always_comb begin
        next_phase     = phase;
        next_sclk_d    = sclk_s;
        next_shift     = shift;
        next_bit_cnt   = bit_cnt;
        next_is_read   = is_read;
        next_sdo_shift = sdo_shift;
        next_sdo       = o_SDO;
        next_sdo_oe    = 1'b0;
        wr             = '0;
        if (csn_s) begin
            // chip select released: abort any partial frame
            next_phase   = IPAR_IDLE;
            next_bit_cnt = 5'd0;
            next_is_read = 1'b0;
        end else begin
            case (phase)
                IPAR_IDLE: begin
                    next_phase = IPAR_HEADER;
                end
                IPAR_HEADER: begin
                    if (sclk_s && !sclk_d) begin
                        next_shift   = {shift[22:0], sdi_s};
                        next_bit_cnt = bit_cnt + 5'd1;
                        if (bit_cnt == 5'(ipar_pkg::HEADER_BITS - 1)) begin
                            // header complete: fetch read data now
                            next_phase     = IPAR_DATA;
                            next_is_read   = next_shift[ipar_pkg::HEADER_BITS-1];
                            next_sdo_shift = read_value(next_shift[14:0], mode_b,
                                                        mode_c, mode_d, flags,
                                                        summary, i_INIT_DONE);
                        end
                    end
                end
                IPAR_DATA: begin
                    next_sdo_oe = is_read;
                    if (!sclk_s && sclk_d && is_read) begin
                        next_sdo       = sdo_shift[7];
                        next_sdo_shift = {sdo_shift[6:0], 1'b0};
                    end
                    if (sclk_s && !sclk_d) begin
                        next_shift   = {shift[22:0], sdi_s};
                        next_bit_cnt = bit_cnt + 5'd1;
                        if (bit_cnt == 5'(ipar_pkg::FRAME_BITS - 1)) begin
                            next_phase = IPAR_IDLE;
                            next_sdo_oe = 1'b0;
                            wr.en   = !next_shift[ipar_pkg::CMD_READ_POS];
                            wr.addr = next_shift[22:8];
                            wr.data = next_shift[7:0];
                        end
                    end
                end
                default: begin
                    next_phase = IPAR_IDLE;
                end
            endcase
        end
    end

    // serial engine registers
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            phase     <= IPAR_IDLE;
            sclk_d    <= 1'b0;
            shift     <= 24'h00_0000;
            bit_cnt   <= 5'd0;
            is_read   <= 1'b0;
            sdo_shift <= 8'h00;
            o_SDO     <= 1'b0;
            o_SDO_OE  <= 1'b0;
        end else begin
            phase     <= next_phase;
            sclk_d    <= next_sclk_d;
            shift     <= next_shift;
            bit_cnt   <= next_bit_cnt;
            is_read   <= next_is_read;
            sdo_shift <= next_sdo_shift;
            o_SDO     <= next_sdo;
            o_SDO_OE  <= next_sdo_oe;
        end
    end

    // summary is a plain gate so a read sees the flags of that very cycle
    assign summary = |(flags & ~i_ALARM_DISABLE_BITS);

    // alarm sources; the reserved bit 1 is never set by hardware
    always_comb begin
        set_evt = '0;
        set_evt[ipar_pkg::POS_FIFO_FAULT] =
            |(i_LANE_ACTIVE & (i_LANE_FIFO_UNDERFLOW | i_LANE_FIFO_OVERFLOW));
        set_evt[ipar_pkg::POS_PLL_UNLOCK]   = i_ALARM_EVENTS.serializer_pll_unlock;
        set_evt[ipar_pkg::POS_LINK_DOWN]    = i_ALARM_EVENTS.link_not_running;
        set_evt[ipar_pkg::POS_REALIGN]      = i_ALARM_EVENTS.clock_realign_event;
        set_evt[ipar_pkg::POS_DIV_MISMATCH] = i_ALARM_EVENTS.divider_mismatch;
    end

    // register bank next values
    always_comb begin
        next_mode_b = mode_b;
        next_mode_c = mode_c;
        next_mode_d = mode_d;
        clr_req     = '0;
        if (wr.en) begin
            case (wr.addr)
                // reserved codes are dropped so the core never sees them
                ipar_pkg::OFS_MODE_B: begin
                    if (code_legal(wr.data, ipar_pkg::MODE_B_LOW,
                                   ipar_pkg::MODE_B_HIGH)) begin
                        next_mode_b = wr.data;
                    end
                end
                ipar_pkg::OFS_MODE_C: begin
                    if (code_legal(wr.data, ipar_pkg::MODE_C_LOW,
                                   ipar_pkg::MODE_C_HIGH)) begin
                        next_mode_c = wr.data;
                    end
                end
                ipar_pkg::OFS_MODE_D: begin
                    if (code_legal(wr.data, ipar_pkg::MODE_D_LOW,
                                   ipar_pkg::MODE_D_HIGH)) begin
                        next_mode_d = wr.data;
                    end
                end
                ipar_pkg::OFS_ALARM_FLAGS: begin
                    clr_req = wr.data[5:0];
                end
                default: begin
                    clr_req = '0;
                end
            endcase
        end
        // a hardware set in the same cycle as a clear wins
        next_flags = (flags & ~clr_req) | set_evt;
        if (i_SOFT_RESET) begin
            next_mode_b = ipar_pkg::MODE_B_HIGH;
            next_mode_c = ipar_pkg::MODE_C_HIGH;
            next_mode_d = ipar_pkg::MODE_D_HIGH;
            next_flags  = ipar_pkg::ALARM_FLAGS_RST;
        end
        next_pin = i_STATUS_PIN_SEL_ALARM ? summary : i_CAL_STATUS;
    end

    // register bank flops
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mode_b              <= ipar_pkg::MODE_B_HIGH;
            mode_c              <= ipar_pkg::MODE_C_HIGH;
            mode_d              <= ipar_pkg::MODE_D_HIGH;
            flags               <= ipar_pkg::ALARM_FLAGS_RST;
            o_STATUS_OUTPUT_PIN <= 1'b0;
            o_MODE_CODE_B       <= ipar_pkg::MODE_B_HIGH;
            o_MODE_CODE_C       <= ipar_pkg::MODE_C_HIGH;
            o_MODE_CODE_D       <= ipar_pkg::MODE_D_HIGH;
        end else begin
            mode_b              <= next_mode_b;
            mode_c              <= next_mode_c;
            mode_d              <= next_mode_d;
            flags               <= next_flags;
            o_STATUS_OUTPUT_PIN <= next_pin;
            o_MODE_CODE_B       <= next_mode_b;
            o_MODE_CODE_C       <= next_mode_c;
            o_MODE_CODE_D       <= next_mode_d;
        end
    end

    // checks
    default clocking ck @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);

    sequence s_flag_write;
        wr.en && (wr.addr == ipar_pkg::OFS_ALARM_FLAGS);
    endsequence

    a_summary_or: assert property (
        summary == |(flags & ~i_ALARM_DISABLE_BITS))
        else $error("summary differs from unmasked flags");

    a_mask_excludes: assert property (
        ((flags & ~i_ALARM_DISABLE_BITS) == 6'h00) |-> !summary)
        else $error("masked alarm reached summary");

    a_pin_route: assert property (
        i_STATUS_PIN_SEL_ALARM |=> (o_STATUS_OUTPUT_PIN == $past(summary)))
        else $error("status pin not following summary");

    a_flag_clear: assert property (
        s_flag_write ##0 (wr.data[3] && !set_evt[3] && !i_SOFT_RESET) |=> !flags[3])
        else $error("write one did not clear flag");

    a_flag_sticky: assert property (
        (flags[0] && !(wr.en && wr.addr == ipar_pkg::OFS_ALARM_FLAGS && wr.data[0]))
        |=> flags[0])
        else $error("flag dropped without a clear");

    a_set_wins: assert property (
        (|(i_LANE_ACTIVE & (i_LANE_FIFO_UNDERFLOW | i_LANE_FIFO_OVERFLOW)))
        |=> flags[ipar_pkg::POS_FIFO_FAULT])
        else $error("fifo fault not recorded");

    a_code_b_legal: assert property (
        code_legal(mode_b, ipar_pkg::MODE_B_LOW, ipar_pkg::MODE_B_HIGH))
        else $error("mode b holds a reserved code");

    a_code_cd_legal: assert property (
        code_legal(mode_c, ipar_pkg::MODE_C_LOW, ipar_pkg::MODE_C_HIGH)
        && code_legal(mode_d, ipar_pkg::MODE_D_LOW, ipar_pkg::MODE_D_HIGH))
        else $error("mode c or d holds a reserved code");

    a_soft_reset: assert property (
        i_SOFT_RESET |=> (flags == ipar_pkg::ALARM_FLAGS_RST)
                         && (mode_d == ipar_pkg::MODE_D_HIGH))
        else $error("soft reset did not restore defaults");

    a_init_read: assert property (
        (phase == IPAR_HEADER && next_phase == IPAR_DATA
         && next_shift[14:0] == ipar_pkg::OFS_STARTUP_DONE)
        |=> sdo_shift == {7'h00, $past(i_INIT_DONE)})
        else $error("init status read wrong");

endmodule : ipar_regs

//--- test/ipar_regs_test.sv
// self-checking bench for the init, power mode and alarm register bank
// assumes ipar_pkg and the design are compiled first; the bench drives every pin itself
`timescale 1ns/100ps
module ipar_regs_test;
    localparam int HALF = 6;                 // mclk cycles per serial clock level, min is 3
    // clock, resets and serial pins
    logic                      mclk      = 1'b0;
    logic                      sys_rst   = 1'b1;
    logic                      soft_rst  = 1'b0;
    logic                      sclk      = 1'b0;
    logic                      scs_n     = 1'b1;
    logic                      sdi       = 1'b0;
    logic                      sdo;
    logic                      sdo_oe;
    // core status and alarm sources
    logic                      init_done = 1'b0;
    logic [7:0]                lane_act  = 8'h00;
    logic [7:0]                lane_unf  = 8'h00;
    logic [7:0]                lane_ovf  = 8'h00;
    ipar_pkg::ipar_alarm_evt_t alarm_evt = '0;
    logic [5:0]                mask      = 6'h3F;  // all sources disabled, as after reset
    logic                      pin_sel   = 1'b1;
    logic                      cal_stat  = 1'b0;
    logic                      pin;
    logic [7:0]                code_b;
    logic [7:0]                code_c;
    logic [7:0]                code_d;
    // bookkeeping
    int                        num_errors = 0;
    int                        checked    = 0;

    ipar_regs #(.LANES(8)) ipar_regs_inst (
        .I_MCLK(mclk), .I_SYS_RST(sys_rst), .i_SOFT_RESET(soft_rst),
        .i_SCLK(sclk), .i_SCS_N(scs_n), .i_SDI(sdi), .o_SDO(sdo), .o_SDO_OE(sdo_oe),
        .i_INIT_DONE(init_done), .i_LANE_ACTIVE(lane_act),
        .i_LANE_FIFO_UNDERFLOW(lane_unf), .i_LANE_FIFO_OVERFLOW(lane_ovf),
        .i_ALARM_EVENTS(alarm_evt), .i_ALARM_DISABLE_BITS(mask),
        .i_STATUS_PIN_SEL_ALARM(pin_sel), .i_CAL_STATUS(cal_stat),
        .o_STATUS_OUTPUT_PIN(pin), .o_MODE_CODE_B(code_b), .o_MODE_CODE_C(code_c),
        .o_MODE_CODE_D(code_d)
    );

    // 50 ns period
    initial begin
        forever #25 mclk = ~mclk;
    end

    // inputs always move 1 ns after a rising edge, clear of the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one 24-bit frame, msb first; each pin level is held long enough for the synchroniser
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rd, addr, wd};
        rdat  = 8'h00;
        scs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = frame[i];
            tick(HALF);
            if (i < 8) rdat[i] = sdo;     // read bits sampled just before the rising edge
            if (i < 8) check("sdo_oe", {7'h00, sdo_oe}, {7'h00, rd}); // enable only on reads
            sclk = 1'b1;
            tick(HALF);
            sclk = 1'b0;
        end
        tick(HALF);
        scs_n = 1'b1;
        tick(HALF);                        // covers commit latency and the idle gap
        check("sdo_oe_end", {7'h00, sdo_oe}, 8'h00);
    endtask : xfer

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(1'b0, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] v;
        xfer(1'b1, a, 8'h00, v);
        check(nm, v, exp);
    endtask : rd_chk

    // reset contents; host waits for init done before any frame
    task automatic test_reset_values;
        init_done = 1'b1;
        tick(2);
        rd_chk("startup", ipar_pkg::OFS_STARTUP_DONE, 8'h01);
        rd_chk("mode_b", ipar_pkg::OFS_MODE_B, 8'h0F);
        rd_chk("mode_c", ipar_pkg::OFS_MODE_C, 8'h04);
        rd_chk("mode_d", ipar_pkg::OFS_MODE_D, 8'h1B);
        check("codes", code_b ^ code_c ^ code_d, 8'h0F ^ 8'h04 ^ 8'h1B);
        rd_chk("flags", ipar_pkg::OFS_ALARM_FLAGS, 8'h3F);
        rd_chk("summary", ipar_pkg::OFS_ALARM_SUM, 8'h00);
        rd_chk("unmapped", 15'h0300, 8'h00);
    endtask : test_reset_values

    // all three codes go low together, a reserved code is refused on b and on c, then back to high
    task automatic test_modes;
        logic [14:0] ofs [3];
        logic [7:0]  lo [3];
        logic [7:0]  hi [3];
        ofs = '{ipar_pkg::OFS_MODE_B, ipar_pkg::OFS_MODE_C, ipar_pkg::OFS_MODE_D};
        lo  = '{8'h06, 8'h00, 8'h14};
        hi  = '{8'h0F, 8'h04, 8'h1B};
        // the bench plays a host at or below the low-power rate, cal and link enables off
        for (int k = 0; k < 3; k++) wr(ofs[k], lo[k]);
        for (int k = 0; k < 3; k++) rd_chk("mode_lo", ofs[k], lo[k]);
        check("code_b_lo", code_b, 8'h06);
        check("code_d_lo", code_d, 8'h14);
        wr(ofs[0], 8'h07);
        rd_chk("mode_b_rsv", ofs[0], 8'h06);
        wr(ofs[1], 8'h05);
        rd_chk("mode_c_rsv", ofs[1], 8'h00);
        // a real host calibrates after each switch; no converted data is used here
        for (int k = 0; k < 3; k++) wr(ofs[k], hi[k]);
        for (int k = 0; k < 3; k++) rd_chk("mode_hi", ofs[k], hi[k]);
        check("code_c_hi", code_c, 8'h04);
    endtask : test_modes

    // sticky flags, write-one-clear, masking, pin routing, soft reset
    task automatic test_alarms;
        int pos [4];
        pos  = '{4, 3, 2, 0};               // event struct is msb first
        mask = 6'h00;
        tick(3);
        check("pin_set", {7'h00, pin}, 8'h01);
        rd_chk("sum_set", ipar_pkg::OFS_ALARM_SUM, 8'h01);
        wr(ipar_pkg::OFS_ALARM_FLAGS, 8'h3F);
        rd_chk("flags_clr", ipar_pkg::OFS_ALARM_FLAGS, 8'h00);
        rd_chk("sum_clr", ipar_pkg::OFS_ALARM_SUM, 8'h00);
        check("pin_clr", {7'h00, pin}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            alarm_evt = ipar_pkg::ipar_alarm_evt_t'(4'b1000 >> k);
            tick(1);
            alarm_evt = '0;
            tick(1);
            rd_chk("evt_flag", ipar_pkg::OFS_ALARM_FLAGS, 8'h01 << pos[k]);
            wr(ipar_pkg::OFS_ALARM_FLAGS, 8'h00);
            rd_chk("w0_keep", ipar_pkg::OFS_ALARM_FLAGS, 8'h01 << pos[k]);
            mask = 6'h01 << pos[k];
            rd_chk("masked", ipar_pkg::OFS_ALARM_SUM, 8'h00);
            mask = 6'h00;
            rd_chk("unmasked", ipar_pkg::OFS_ALARM_SUM, 8'h01);
            wr(ipar_pkg::OFS_ALARM_FLAGS, 8'h01 << pos[k]);
        end
        lane_act = 8'h01;
        lane_ovf = 8'h02;                   // fault on an idle lane must not count
        tick(1);
        lane_ovf = 8'h00;
        rd_chk("idle_lane", ipar_pkg::OFS_ALARM_FLAGS, 8'h00);
        lane_unf = 8'h01;
        tick(1);
        lane_unf = 8'h00;
        rd_chk("fifo_flag", ipar_pkg::OFS_ALARM_FLAGS, 8'h20);
        pin_sel  = 1'b0;
        cal_stat = 1'b1;
        mask     = 6'h3F;
        tick(3);
        check("pin_cal", {7'h00, pin}, 8'h01);
        pin_sel = 1'b1;
        tick(3);
        check("pin_mask", {7'h00, pin}, 8'h00);
        soft_rst = 1'b1;
        tick(1);
        soft_rst = 1'b0;
        tick(3);
        rd_chk("flags_srst", ipar_pkg::OFS_ALARM_FLAGS, 8'h3F);
    endtask : test_alarms

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // watchdog: the whole sequence needs far fewer cycles than this
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        tick(4);
        test_reset_values();
        test_modes();
        test_alarms();
        stop_test();
    end
endmodule : ipar_regs_test
